// file: logic/hifcl_cfg.svh
// constants for the host interrupt, fifo and clock block
`ifndef HIFCL_CFG_SVH
`define HIFCL_CFG_SVH
`define HIFCL_FIFO_BYTES  10'h200
`define HIFCL_FIFO_AW     9
`define HIFCL_STAGE_DEPTH 8
`define HIFCL_NREG        4
`define HIFCL_IRQ_MAIN    2'h0
`define HIFCL_IRQ_TIMER   2'h1
`define HIFCL_IRQ_ERR     2'h2
`define HIFCL_IRQ_TGT     2'h3
`define HIFCL_SLOT_LOW_BIT 7
`define HIFCL_PT_BYTES    6'h30
`define HIFCL_PT_ID_BYTES 10
`define HIFCL_PT_ID4_LEN  4
`define HIFCL_PT_ID7_LEN  7
`define HIFCL_PT_SENS_HI  6'h0a
`define HIFCL_PT_SENS_LO  6'h0b
`define HIFCL_PT_SEL1     6'h0c
`define HIFCL_PT_SEL2     6'h0d
`define HIFCL_PT_SC_HI    6'h0f
`define HIFCL_PT_SC_LO    6'h10
`define HIFCL_PT_POLL     6'h11
`define HIFCL_PT_RD_HI    6'h22
`define HIFCL_PT_RD_LO    6'h23
`define HIFCL_PT_TSN      6'h24
`define HIFCL_SLOTS       5'h18
`define HIFCL_SLOT_LOW    5'h04
`define HIFCL_POLL_BODY   5'h11
`define HIFCL_POLL_FULL   5'h13
`define HIFCL_SC_ANY      16'hffff
`define HIFCL_RC_SC       8'h01
`define HIFCL_RC_PERF     8'h02
`define HIFCL_CLK_KHZ     100000
`define HIFCL_NCO_W       16
`define HIFCL_F1_KHZ      13560
`define HIFCL_F2_KHZ      6780
`define HIFCL_F3_KHZ      3390
`define HIFCL_LF_KHZ      32
`define HIFCL_INC(f) (((f) * 65536) / `HIFCL_CLK_KHZ)
`define HIFCL_LF_OFF_DEFAULT 1'b0
`endif

// file: logic/hifcl_pkg.sv
// types shared by the host interrupt, fifo and clock block
package hifcl_pkg;
  typedef logic [7:0] hifcl_byte_t;
  typedef enum logic [1:0] {
    hifcl_clk_off = 2'h0,
    hifcl_clk_f1  = 2'h1,
    hifcl_clk_f2  = 2'h2,
    hifcl_clk_f3  = 2'h3
  } hifcl_clk_sel_t;
endpackage

// file: logic/hifcl_top.sv
// host interrupt, fifo, target memory and clock output logic
`timescale 1ns/1ps
`include "hifcl_cfg.svh"

module hifcl_stage_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clr_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             load;

  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign push = in_valid_i & in_ready_o;
  assign load = (cnt_reg != '0) & (~out_valid_o | out_ready_i);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clr_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // output register so the consumer sees flopped data
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clr_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (load) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rd_ptr_reg];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule

module hifcl_top (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 cmd_set_default_i,
  input  wire logic                 cmd_stop_all_i,
  input  wire logic                 cmd_clear_fifo_i,
  input  wire logic                 rx_start_i,
  input  wire logic [7:0]           irq_main_evt_i,
  input  wire logic [7:0]           irq_timer_evt_i,
  input  wire logic [7:0]           irq_err_evt_i,
  input  wire logic [7:0]           irq_tgt_evt_i,
  input  wire logic [7:0]           irq_main_mask_i,
  input  wire logic [7:0]           irq_timer_mask_i,
  input  wire logic [7:0]           irq_err_mask_i,
  input  wire logic [7:0]           irq_tgt_mask_i,
  input  wire logic                 irq_rd_i,
  input  wire logic [1:0]           irq_rd_sel_i,
  output logic      [7:0]           irq_rd_data_o,
  output logic                      irq_o,
  input  wire logic                 host_wr_i,
  input  wire hifcl_pkg::hifcl_byte_t host_wdata_i,
  input  wire logic                 host_rd_i,
  output hifcl_pkg::hifcl_byte_t    host_rdata_o,
  input  wire logic                 rx_wr_i,
  input  wire hifcl_pkg::hifcl_byte_t rx_data_i,
  input  wire logic                 tx_active_i,
  output logic                      tx_valid_o,
  output hifcl_pkg::hifcl_byte_t    tx_data_o,
  input  wire logic                 tx_ready_i,
  output logic      [9:0]           fifo_count_o,
  output logic                      fifo_overflow_o,
  output logic                      fifo_underflow_o,
  input  wire logic                 pt_wr_i,
  input  wire logic                 pt_rd_i,
  input  wire logic [5:0]           pt_addr_i,
  input  wire hifcl_pkg::hifcl_byte_t pt_wdata_i,
  output hifcl_pkg::hifcl_byte_t    pt_rdata_o,
  input  wire logic                 id_len7_i,
  output logic      [79:0]          nfca_id_o,
  output logic      [15:0]          nfca_sens_res_o,
  output hifcl_pkg::hifcl_byte_t    select_level1_response_o,
  output hifcl_pkg::hifcl_byte_t    select_level2_response_o,
  input  wire logic                 poll_req_i,
  input  wire logic [15:0]          poll_sc_i,
  input  wire logic [7:0]           poll_rc_i,
  input  wire logic [7:0]           poll_slots_i,
  output logic                      poll_resp_o,
  output logic      [4:0]           poll_len_o,
  output logic      [3:0]           poll_slot_o,
  input  wire logic [4:0]           resp_idx_i,
  output hifcl_pkg::hifcl_byte_t    resp_byte_o,
  input  wire logic                 clk_cfg_load_i,
  input  wire hifcl_pkg::hifcl_clk_sel_t clk_sel_i,
  input  wire logic                 lf_clk_off_i,
  input  wire logic                 xtal_running_i,
  output logic                      mcu_clk_o,
  input  wire logic                 if_sel_pin_i,
  output logic                      spi_en_o,
  output logic                      i2c_en_o
);
  import hifcl_pkg::*;

  // interrupt status
  logic [7:0] evt_vec  [`HIFCL_NREG];
  logic [7:0] mask_vec [`HIFCL_NREG];
  logic [7:0] stat_vec [`HIFCL_NREG];
  logic [`HIFCL_NREG-1:0] pend;
  logic       clear_all;
  logic       slot_low_reg;

  assign clear_all = cmd_set_default_i | cmd_stop_all_i
                   | cmd_clear_fifo_i;
  assign evt_vec[0]  = irq_main_evt_i;
  assign evt_vec[1]  = irq_timer_evt_i;
  assign evt_vec[2]  = irq_err_evt_i;
  assign evt_vec[3]  = irq_tgt_evt_i
    | (8'(slot_low_reg) << `HIFCL_SLOT_LOW_BIT);
  assign mask_vec[0] = irq_main_mask_i;
  assign mask_vec[1] = irq_timer_mask_i;
  assign mask_vec[2] = irq_err_mask_i;
  assign mask_vec[3] = irq_tgt_mask_i;

  for (genvar g = 0; g < `HIFCL_NREG; g++) begin : g_irq
    logic [7:0] st_reg;
    logic       rd_hit;
    assign rd_hit = irq_rd_i & (irq_rd_sel_i == 2'(g));
    // new events win over the clear in the same cycle
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        st_reg <= '0;
      end else if (clear_all || rd_hit) begin
        st_reg <= evt_vec[g];
      end else begin
        st_reg <= st_reg | evt_vec[g];
      end
    end
    assign stat_vec[g] = st_reg;
    assign pend[g] = |(st_reg & ~mask_vec[g]);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |pend;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_rd_data_o <= '0;
    end else if (irq_rd_i) begin
      irq_rd_data_o <= stat_vec[irq_rd_sel_i];
    end
  end

  // main fifo
  hifcl_byte_t fifo_mem [`HIFCL_FIFO_BYTES];
  logic [`HIFCL_FIFO_AW-1:0] wr_ptr_reg;
  logic [`HIFCL_FIFO_AW-1:0] rd_ptr_reg;
  logic [9:0]  cnt_reg;
  logic        flush;
  logic        empty;
  logic        full;
  logic        wr_req;
  logic        wr_do;
  logic        rd_stage;
  logic        rd_do;
  logic        stage_ready;
  hifcl_byte_t wr_data;

  assign flush = rx_start_i | cmd_set_default_i
               | cmd_clear_fifo_i;
  assign empty = (cnt_reg == '0);
  assign full  = (cnt_reg == `HIFCL_FIFO_BYTES);
  assign wr_req  = rx_wr_i | host_wr_i;
  assign wr_data = rx_wr_i ? rx_data_i : host_wdata_i;
  assign wr_do   = wr_req & ~full & ~flush;
  assign rd_stage = tx_active_i & ~host_rd_i & stage_ready;
  assign rd_do   = (host_rd_i | rd_stage) & ~empty & ~flush;

  always_ff @(posedge clk_i) begin
    if (wr_do) begin
      fifo_mem[wr_ptr_reg] <= wr_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (wr_do) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (rd_do) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + 10'(wr_do) - 10'(rd_do);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fifo_count_o <= '0;
    end else begin
      fifo_count_o <= flush ? '0 : cnt_reg + 10'(wr_do) - 10'(rd_do);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      host_rdata_o <= '0;
    end else if (host_rd_i) begin
      host_rdata_o <= rd_do ? fifo_mem[rd_ptr_reg] : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || flush) begin
      fifo_overflow_o <= 1'b0;
    end else if (wr_req && full) begin
      fifo_overflow_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || flush) begin
      fifo_underflow_o <= 1'b0;
    end else if ((host_rd_i && empty) || (tx_active_i && tx_ready_i
                 && !tx_valid_o && empty)) begin
      fifo_underflow_o <= 1'b1;
    end
  end

  hifcl_stage_fifo #(
    .WIDTH (8),
    .DEPTH (`HIFCL_STAGE_DEPTH)
  ) u_stage (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .clr_i       (flush),
    .in_valid_i  (rd_stage & rd_do),
    .in_data_i   (fifo_mem[rd_ptr_reg]),
    .in_ready_o  (stage_ready),
    .out_valid_o (tx_valid_o),
    .out_data_o  (tx_data_o),
    .out_ready_i (tx_ready_i)
  );

  // target response memory
  hifcl_byte_t pt_mem [`HIFCL_PT_BYTES];
  logic [4:0]  slot_ptr_reg;
  logic [15:0] stored_system_code;
  logic        sc_match;
  hifcl_byte_t slot_byte;
  logic [3:0]  slot_nib;
  logic [3:0]  slot_num;
  logic [4:0]  slot_next;
  logic [15:0] rd_pick;
  logic [15:0] rd_bytes_reg;

  always_ff @(posedge clk_i) begin
    if (pt_wr_i && pt_addr_i < `HIFCL_PT_BYTES) begin
      pt_mem[pt_addr_i] <= pt_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pt_rdata_o <= '0;
    end else if (pt_rd_i) begin
      pt_rdata_o <= (pt_addr_i < `HIFCL_PT_BYTES)
                  ? pt_mem[pt_addr_i] : '0;
    end
  end

  for (genvar i = 0; i < `HIFCL_PT_ID_BYTES; i++) begin : g_id
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        nfca_id_o[8*i +: 8] <= '0;
      end else if (i < (id_len7_i ? `HIFCL_PT_ID7_LEN
                                  : `HIFCL_PT_ID4_LEN)) begin
        nfca_id_o[8*i +: 8] <= pt_mem[i];
      end else begin
        nfca_id_o[8*i +: 8] <= '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      nfca_sens_res_o          <= '0;
      select_level1_response_o <= '0;
      select_level2_response_o <= '0;
    end else begin
      nfca_sens_res_o <= {pt_mem[`HIFCL_PT_SENS_HI],
                          pt_mem[`HIFCL_PT_SENS_LO]};
      select_level1_response_o <= pt_mem[`HIFCL_PT_SEL1];
      select_level2_response_o <= pt_mem[`HIFCL_PT_SEL2];
    end
  end

  assign stored_system_code = {pt_mem[`HIFCL_PT_SC_HI],
                               pt_mem[`HIFCL_PT_SC_LO]};
  assign sc_match = (poll_sc_i == stored_system_code)
                  | (poll_sc_i == `HIFCL_SC_ANY);
  assign slot_byte = pt_mem[`HIFCL_PT_TSN + 6'(slot_ptr_reg[4:1])];
  assign slot_nib  = slot_ptr_reg[0] ? slot_byte[7:4]
                                     : slot_byte[3:0];
  assign slot_next = (slot_ptr_reg == `HIFCL_SLOTS - 5'h01)
                   ? '0 : slot_ptr_reg + 5'h01;

  always_comb begin
    case (poll_slots_i)
      8'h00:   slot_num = 4'h0;
      8'h01:   slot_num = {3'h0, slot_nib[3]};
      8'h03:   slot_num = {2'h0, slot_nib[3:2]};
      8'h07:   slot_num = {1'h0, slot_nib[3:1]};
      default: slot_num = slot_nib;
    endcase
  end

  always_comb begin
    case (poll_rc_i)
      `HIFCL_RC_SC:   rd_pick = stored_system_code;
      `HIFCL_RC_PERF: rd_pick = {pt_mem[`HIFCL_PT_RD_HI],
                                 pt_mem[`HIFCL_PT_RD_LO]};
      default:        rd_pick = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      slot_ptr_reg <= '0;
      slot_low_reg <= 1'b0;
    end else if (pt_wr_i && pt_addr_i == `HIFCL_PT_TSN) begin
      slot_ptr_reg <= '0;
      slot_low_reg <= 1'b0;
    end else if (poll_req_i && sc_match) begin
      slot_ptr_reg <= slot_next;
      slot_low_reg <= (`HIFCL_SLOTS - slot_ptr_reg - 5'h01
                       == `HIFCL_SLOT_LOW);
    end else begin
      slot_low_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      poll_resp_o  <= 1'b0;
      poll_len_o   <= '0;
      poll_slot_o  <= '0;
      rd_bytes_reg <= '0;
    end else begin
      poll_resp_o <= poll_req_i & sc_match;
      if (poll_req_i && sc_match) begin
        poll_len_o   <= (poll_rc_i == `HIFCL_RC_SC
                      || poll_rc_i == `HIFCL_RC_PERF)
                      ? `HIFCL_POLL_FULL : `HIFCL_POLL_BODY;
        poll_slot_o  <= slot_num;
        rd_bytes_reg <= rd_pick;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resp_byte_o <= '0;
    end else if (resp_idx_i < `HIFCL_POLL_BODY) begin
      resp_byte_o <= pt_mem[`HIFCL_PT_POLL + 6'(resp_idx_i)];
    end else if (resp_idx_i == `HIFCL_POLL_BODY) begin
      resp_byte_o <= rd_bytes_reg[15:8];
    end else if (resp_idx_i == `HIFCL_POLL_BODY + 5'h01) begin
      resp_byte_o <= rd_bytes_reg[7:0];
    end else begin
      resp_byte_o <= '0;
    end
  end

  // host clock output, phase accumulator on the system clock
  hifcl_clk_sel_t          clk_sel_reg;
  logic                    lf_off_reg;
  logic [`HIFCL_NCO_W-1:0] acc_reg;
  logic [`HIFCL_NCO_W-1:0] inc;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clk_sel_reg <= hifcl_clk_f3;
      lf_off_reg  <= `HIFCL_LF_OFF_DEFAULT;
    end else if (clk_cfg_load_i) begin
      clk_sel_reg <= clk_sel_i;
      lf_off_reg  <= lf_clk_off_i;
    end
  end

  always_comb begin
    inc = '0;
    if (xtal_running_i) begin
      case (clk_sel_reg)
        hifcl_clk_f1: inc = 16'(`HIFCL_INC(`HIFCL_F1_KHZ));
        hifcl_clk_f2: inc = 16'(`HIFCL_INC(`HIFCL_F2_KHZ));
        hifcl_clk_f3: inc = 16'(`HIFCL_INC(`HIFCL_F3_KHZ));
        default:      inc = '0;
      endcase
    end else if (!lf_off_reg) begin
      inc = 16'(`HIFCL_INC(`HIFCL_LF_KHZ));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || inc == '0) begin
      acc_reg   <= '0;
      mcu_clk_o <= 1'b0;
    end else begin
      acc_reg   <= acc_reg + inc;
      mcu_clk_o <= acc_reg[`HIFCL_NCO_W-1];
    end
  end

  // interface strap caught once after reset release
  logic strap_done_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      strap_done_reg <= 1'b0;
      spi_en_o       <= 1'b0;
      i2c_en_o       <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      spi_en_o       <= ~if_sel_pin_i;
      i2c_en_o       <= if_sel_pin_i;
    end
  end
endmodule

// file: tb/hifcl_asserts.sv
// concurrent checks on the irq, fifo, poll and strap ports
`timescale 1ns/1ps
module hifcl_asserts (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        cmd_set_default_i,
  input wire logic        cmd_stop_all_i,
  input wire logic        cmd_clear_fifo_i,
  input wire logic        rx_start_i,
  input wire logic [7:0]  irq_main_evt_i,
  input wire logic [7:0]  irq_timer_evt_i,
  input wire logic [7:0]  irq_err_evt_i,
  input wire logic [7:0]  irq_tgt_evt_i,
  input wire logic [7:0]  irq_main_mask_i,
  input wire logic        irq_rd_i,
  input wire logic [1:0]  irq_rd_sel_i,
  input wire logic [7:0]  irq_rd_data_o,
  input wire logic        irq_o,
  input wire logic        host_wr_i,
  input wire logic        host_rd_i,
  input wire logic [7:0]  host_rdata_o,
  input wire logic        rx_wr_i,
  input wire logic        tx_active_i,
  input wire logic [9:0]  fifo_count_o,
  input wire logic        fifo_overflow_o,
  input wire logic        fifo_underflow_o,
  input wire logic        poll_req_i,
  input wire logic [15:0] poll_sc_i,
  input wire logic        poll_resp_o,
  input wire logic        if_sel_pin_i,
  input wire logic        spi_en_o,
  input wire logic        i2c_en_o
);
  logic clr;
  logic ff;
  logic evts;
  assign clr = cmd_set_default_i | cmd_stop_all_i | cmd_clear_fifo_i;
  assign ff = cmd_set_default_i | cmd_clear_fifo_i | rx_start_i;
  assign evts = |{irq_main_evt_i, irq_timer_evt_i, irq_err_evt_i,
                  irq_tgt_evt_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_main_up;
    irq_main_evt_i[0] && !irq_main_mask_i[0] && !irq_rd_i && !clr;
  endsequence
  sequence s_hold_up;
    !irq_main_mask_i[0] && !irq_rd_i && !clr;
  endsequence
  sequence s_rd_twice;
    irq_rd_i && !evts ##1 irq_rd_i && !evts && $stable(irq_rd_sel_i);
  endsequence
  a_irq_rise: assert property (
    s_main_up ##1 s_hold_up |-> ##1 irq_o) else $error("irq not raised");
  a_cmd_clear: assert property (
    clr && !evts ##1 !evts |-> ##1 !irq_o) else $error("irq kept");
  a_read_clears: assert property (
    s_rd_twice |=> irq_rd_data_o == 8'h00) else $error("status kept");
  a_empty_zero: assert property (
    host_rd_i && !host_wr_i && !rx_wr_i && fifo_count_o == 10'h000
    |=> host_rdata_o == 8'h00) else $error("empty read not zero");
  a_underflow: assert property (
    host_rd_i && !host_wr_i && !rx_wr_i && !ff && fifo_count_o == 10'h000
    |=> fifo_underflow_o) else $error("no underflow");
  a_overflow: assert property (
    host_wr_i && !rx_wr_i && !host_rd_i && !tx_active_i && !ff &&
    fifo_count_o == 10'h200 |=> fifo_overflow_o) else $error("no overflow");
  a_fifo_flush: assert property (
    ff |=> fifo_count_o == 10'h000 && !fifo_overflow_o && !fifo_underflow_o)
    else $error("fifo not flushed");
  a_poll_any: assert property (
    poll_req_i && poll_sc_i == 16'hffff |=> poll_resp_o)
    else $error("wildcard poll unanswered");
  a_resp_cause: assert property (
    poll_resp_o |-> $past(poll_req_i)) else $error("unrequested reply");
  a_if_select: assert property (
    $past(rst_n_i) && $past(rst_n_i, 2) && $past(rst_n_i, 3) |->
    spi_en_o == !if_sel_pin_i && i2c_en_o == if_sel_pin_i)
    else $error("wrong host interface");
endmodule
bind hifcl_top hifcl_asserts u_chk (.*);

// file: tb/hifcl_tx_sink.sv
// framing side model draining the transmit stream
`timescale 1ns/1ps
module hifcl_tx_sink (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       stall_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] got [16];
  int         n;
  assign tx_ready_o = !stall_i;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      n <= 0;
    end else if (tx_valid_i && tx_ready_o) begin
      got[n[3:0]] <= tx_data_i;
      n <= n + 1;
    end
  end
endmodule

// file: tb/test_hifcl_top.sv
// self-checking bench for the irq, fifo, poll and clock block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module test_hifcl_top;
  import hifcl_pkg::*;
  logic clk_i, rst_n_i, cmd_set_default_i, cmd_stop_all_i, cmd_clear_fifo_i,
    rx_start_i, irq_rd_i, irq_o, host_wr_i, host_rd_i, rx_wr_i, tx_active_i,
    tx_valid_o, tx_ready_i, fifo_overflow_o, fifo_underflow_o, pt_wr_i,
    pt_rd_i, id_len7_i, poll_req_i, poll_resp_o, clk_cfg_load_i,
    lf_clk_off_i, xtal_running_i, mcu_clk_o, if_sel_pin_i, spi_en_o,
    i2c_en_o, stall;
  logic [7:0] irq_main_evt_i, irq_timer_evt_i, irq_err_evt_i, irq_tgt_evt_i,
    irq_main_mask_i, irq_timer_mask_i, irq_err_mask_i, irq_tgt_mask_i,
    irq_rd_data_o, poll_rc_i, poll_slots_i;
  hifcl_byte_t host_wdata_i, host_rdata_o, rx_data_i, tx_data_o, pt_wdata_i,
    pt_rdata_o, select_level1_response_o, select_level2_response_o,
    resp_byte_o;
  logic [15:0]    nfca_sens_res_o, poll_sc_i;
  logic [79:0]    nfca_id_o;
  logic [9:0]     fifo_count_o;
  logic [5:0]     pt_addr_i;
  logic [4:0]     poll_len_o, resp_idx_i;
  logic [3:0]     poll_slot_o;
  logic [1:0]     irq_rd_sel_i;
  hifcl_clk_sel_t clk_sel_i;
  int             num_errors, checks;
  hifcl_top DUT (.*);
  hifcl_tx_sink u_sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
  always #5 clk_i = ~clk_i;
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task rd_irq(input logic [1:0] s, input logic [7:0] e);
    irq_rd_sel_i = s;
    irq_rd_i = 1;
    tick;
    irq_rd_i = 0;
    `CHK(irq_rd_data_o, e)
  endtask
  task t_irq;
    irq_main_evt_i = 8'h01;
    irq_err_evt_i = 8'h04;
    irq_timer_evt_i = 8'h80;
    tick;
    {irq_main_evt_i, irq_err_evt_i, irq_timer_evt_i} = 0;
    tick;
    `CHK(irq_o, 1'b1)
    irq_rd_sel_i = 2'h0;
    irq_rd_i = 1;
    tick;
    `CHK(irq_rd_data_o, 8'h01)
    tick;
    `CHK(irq_rd_data_o, 8'h00)
    irq_rd_sel_i = 2'h1;
    tick;
    irq_rd_i = 0;
    `CHK(irq_rd_data_o, 8'h80)
    tick;
    `CHK(irq_o, 1'b1)
    rd_irq(2'h2, 8'h04);
    tick;
    `CHK(irq_o, 1'b0)
  endtask
  task t_mask;
    irq_tgt_mask_i = 8'hff;
    irq_tgt_evt_i = 8'h03;
    tick;
    irq_tgt_evt_i = 0;
    repeat (3) tick;
    `CHK(irq_o, 1'b0)
    irq_tgt_mask_i = 8'hfe;
    repeat (2) tick;
    `CHK(irq_o, 1'b1)
    rd_irq(2'h3, 8'h03);
    irq_tgt_mask_i = 0;
    for (int i = 0; i < 3; i++) begin
      irq_main_evt_i = 8'h10;
      tick;
      irq_main_evt_i = 0;
      repeat (2) tick;
      {cmd_clear_fifo_i, cmd_stop_all_i, cmd_set_default_i} = 3'h1 << i;
      tick;
      {cmd_clear_fifo_i, cmd_stop_all_i, cmd_set_default_i} = 3'h0;
      tick;
      `CHK(irq_o, 1'b0)
      rd_irq(2'h0, 8'h00);
    end
  endtask
  task t_fifo;
    host_rd_i = 1;
    tick;
    host_rd_i = 0;
    `CHK(host_rdata_o, 8'h00)
    `CHK(fifo_underflow_o, 1'b1)
    cmd_clear_fifo_i = 1;
    tick;
    cmd_clear_fifo_i = 0;
    `CHK(fifo_underflow_o, 1'b0)
    rx_data_i = 8'h5a;
    rx_wr_i = 1;
    tick;
    rx_wr_i = 0;
    host_rd_i = 1;
    tick;
    host_rd_i = 0;
    `CHK(host_rdata_o, 8'h5a)
    host_wr_i = 1;
    for (int i = 0; i < 513; i++) begin
      host_wdata_i = i[7:0];
      tick;
    end
    host_wr_i = 0;
    `CHK(fifo_count_o, 10'h200)
    `CHK(fifo_overflow_o, 1'b1)
    rx_start_i = 1;
    tick;
    rx_start_i = 0;
    `CHK(fifo_count_o, 10'h000)
    `CHK(fifo_overflow_o, 1'b0)
    host_wr_i = 1;
    for (int i = 0; i < 12; i++) begin
      host_wdata_i = 8'h40 + i[7:0];
      tick;
    end
    host_wr_i = 0;
    stall = 1;
    tx_active_i = 1;
    repeat (20) tick;
    `CHK(tx_valid_o, 1'b1)
    `CHK(u_sink.n, 0)
    stall = 0;
    repeat (100) if (u_sink.n < 12) tick;
    `CHK(u_sink.n, 12)
    if (u_sink.n != 12) give_verdict;
    for (int i = 0; i < 12; i++) begin
      `CHK(u_sink.got[i], 8'h40 + i[7:0])
    end
    repeat (3) tick;
    `CHK(fifo_underflow_o, 1'b1)
    tx_active_i = 0;
  endtask
  task poll(input logic [15:0] sc, input logic [7:0] rc, input logic e);
    poll_sc_i = sc;
    poll_rc_i = rc;
    poll_req_i = 1;
    tick;
    poll_req_i = 0;
    `CHK(poll_resp_o, e)
  endtask
  task t_pt;
    for (int i = 0; i < 48; i++) begin
      pt_addr_i = i[5:0];
      pt_wdata_i = 8'h80 + i[7:0];
      pt_wr_i = 1;
      tick;
      pt_wr_i = 0;
    end
    pt_rd_i = 1;
    tick;
    pt_rd_i = 0;
    `CHK(pt_rdata_o, 8'haf)
    `CHK(nfca_id_o, {48'h0, 32'h83828180})
    id_len7_i = 1;
    repeat (2) tick;
    `CHK(nfca_id_o, {24'h0, 56'h86858483828180})
    `CHK(nfca_sens_res_o, 16'h8a8b)
    `CHK(select_level1_response_o, 8'h8c)
    `CHK(select_level2_response_o, 8'h8d)
    resp_idx_i = 5'h00;
    poll_slots_i = 8'h0f;
    poll(16'h1234, 8'h01, 1'b0);
    tick;
    for (int k = 0; k < 20; k++) begin
      poll(k ? 16'hffff : 16'h8f90, 8'(k % 3), 1'b1);
      `CHK(poll_len_o, (k % 3 == 0) ? 5'h11 : 5'h13)
      `CHK(poll_slot_o, k[0] ? 4'ha : 4'h4 + k[4:1])
      tick;
      if (k == 0) begin
        `CHK(resp_byte_o, 8'h91)
        resp_idx_i = 5'h11;
      end else if (k % 3 != 0) begin
        `CHK(resp_byte_o, (k % 3 == 1) ? 8'h8f : 8'ha2)
      end
      if (k > 17) begin
        irq_rd_sel_i = 2'h3;
        irq_rd_i = 1;
        tick;
        irq_rd_i = 0;
        `CHK(irq_rd_data_o[7], 1'(k == 19))
      end
    end
    // four slots: only the top two bits of nibble 4'he are used
    poll_slots_i = 8'h03;
    poll(16'hffff, 8'h00, 1'b1);
    `CHK(poll_slot_o, 4'h3)
  endtask
  task t_strap;
    host_wr_i = 1;
    tick;
    host_wr_i = 0;
    if_sel_pin_i = 1;
    rst_n_i = 0;
    repeat (3) tick;
    `CHK(fifo_count_o, 10'h000)
    `CHK(fifo_underflow_o, 1'b0)
    rst_n_i = 1;
    repeat (2) tick;
    `CHK(i2c_en_o, 1'b1)
    `CHK(spi_en_o, 1'b0)
  endtask
  task t_clock;
    int   n;
    int   e [4];
    logic p;
    e = '{0, 135, 67, 33};
    xtal_running_i = 1;
    for (int s = 3; s >= 0; s--) begin
      if (s < 3) begin
        clk_sel_i = hifcl_clk_sel_t'(s);
        clk_cfg_load_i = 1;
        tick;
        clk_cfg_load_i = 0;
      end
      n = 0;
      p = mcu_clk_o;
      repeat (1000) begin
        tick;
        n += int'(mcu_clk_o && !p);
        p = mcu_clk_o;
      end
      `CHK(n >= e[s] && n <= e[s] + 1, 1'b1)
    end
    // crystal stopped: low freq clock on by default, then switched off
    xtal_running_i = 0;
    for (int s = 0; s < 2; s++) begin
      n = 0;
      p = mcu_clk_o;
      repeat (4000) begin
        tick;
        n += int'(mcu_clk_o && !p);
        p = mcu_clk_o;
      end
      `CHK(n, 1 - s)
      lf_clk_off_i = 1;
      clk_cfg_load_i = 1;
      tick;
      clk_cfg_load_i = 0;
    end
  endtask
  initial begin
    {clk_i, rst_n_i, cmd_set_default_i, cmd_stop_all_i, cmd_clear_fifo_i,
     rx_start_i, irq_rd_i, host_wr_i, host_rd_i, rx_wr_i, tx_active_i,
     pt_wr_i, pt_rd_i, id_len7_i, poll_req_i, clk_cfg_load_i, lf_clk_off_i,
     xtal_running_i, if_sel_pin_i, stall, irq_main_evt_i, irq_timer_evt_i,
     irq_err_evt_i, irq_tgt_evt_i, irq_main_mask_i, irq_timer_mask_i,
     irq_err_mask_i, irq_tgt_mask_i, poll_rc_i, poll_slots_i, host_wdata_i,
     rx_data_i, pt_wdata_i, poll_sc_i, pt_addr_i, resp_idx_i,
     irq_rd_sel_i} = 0;
    clk_sel_i = hifcl_clk_f3;
    num_errors = 0;
    checks = 0;
    repeat (3) tick;
    rst_n_i = 1;
    repeat (2) tick;
    `CHK(irq_o, 1'b0)
    `CHK(spi_en_o, 1'b1)
    t_irq;
    t_mask;
    t_fifo;
    t_pt;
    t_strap;
    t_clock;
    give_verdict;
  end
endmodule
